// file: rtl/plut_port.sv
// APB register port for the red/green/blue palette tables
// Function
// R1 - Three separate 256-entry tables of 6-bit values hold red, green, blue.
// R2 - The write register reads back as zero whatever was written.
// R3 - Write register bits 31-24 give the entry index for all three tables.
// R4 - In little-endian mode the entry is committed by a write to byte 3.
// R5 - In big-endian mode the entry is committed by a write to byte 0.
// R6 - Writing the write index also loads the read index with it.
// R7 - The host places red at 23-18, green at 15-10 and blue at 7-2.
// R8 - Read register bits 31-24 are a write-only index choosing the entry.
// R9 - Reading the read register returns the entry at 23-18, 15-10, 7-2.
// R10 - Unused bits and the read index read as zero; colour writes ignored.
// R11 - Both indices are zero after reset; table contents stay undefined.
`timescale 1ns/1ps
module plut_port
	import plut_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic host_endian_strap_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o
);
	typedef enum logic [1:0] {PLUT_IDLE, PLUT_WAIT, PLUT_DONE} plut_st_t;

	plut_mem_if mif ();

	plut_mem u_mem (
		.mclk_i(mclk_i),
		.m(mif)
	);

	plut_st_t st_q;
	logic [7:0] widx_q;
	logic [7:0] ridx_q;
	logic [5:0] red_q;
	logic [5:0] grn_q;
	logic [5:0] blu_q;
	logic [31:0] prdata_q;
	logic acc;
	logic wr_w;
	logic wr_r;
	logic rd_r;
	logic commit;
	logic [7:0] widx_d;
	logic [5:0] red_d;
	logic [5:0] grn_d;
	logic [5:0] blu_d;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		return a[11:2] == o[11:2];
	endfunction

	assign acc = psel_i && penable_i;
	assign wr_w = acc && pwrite_i && hit(paddr_i, PLUT_WRITE_PORT_OFS);
	assign wr_r = acc && pwrite_i && hit(paddr_i, PLUT_READ_PORT_OFS);
	assign rd_r = acc && !pwrite_i && hit(paddr_i, PLUT_READ_PORT_OFS);

	// Byte-lane merge so partial writes update only their own fields
	always_comb begin
		widx_d = widx_q;
		red_d = red_q;
		grn_d = grn_q;
		blu_d = blu_q;
		if (wr_w && pready_o) begin
			if (pstrb_i[3]) begin
				widx_d = pwdata_i[PLUT_IDX_LSB +: PLUT_IDX_W]; // R3
			end
			if (pstrb_i[2]) begin
				red_d = pwdata_i[PLUT_RED_LSB +: PLUT_COL_W];
			end
			if (pstrb_i[1]) begin
				grn_d = pwdata_i[PLUT_GRN_LSB +: PLUT_COL_W];
			end
			if (pstrb_i[0]) begin
				blu_d = pwdata_i[PLUT_BLU_LSB +: PLUT_COL_W];
			end
		end
	end

	// Commit lane depends on strap; the opposite lane alone stages data but does not commit
	assign commit = wr_w && pready_o && (host_endian_strap_i ?
		pstrb_i[PLUT_BLU_LANE] : pstrb_i[PLUT_IDX_LANE]); // R4 R5

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			widx_q <= PLUT_IDX_RST; // R11
			red_q <= 6'h00;
			grn_q <= 6'h00;
			blu_q <= 6'h00;
		end else begin
			widx_q <= widx_d;
			red_q <= red_d;
			grn_q <= grn_d;
			blu_q <= blu_d;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ridx_q <= PLUT_IDX_RST; // R11
		end else if (wr_w && pready_o && pstrb_i[PLUT_IDX_LANE]) begin
			ridx_q <= pwdata_i[PLUT_IDX_LSB +: PLUT_IDX_W]; // R6
		end else if (wr_r && pready_o && pstrb_i[PLUT_IDX_LANE]) begin
			ridx_q <= pwdata_i[PLUT_IDX_LSB +: PLUT_IDX_W]; // R8
		end
	end

	assign mif.we = commit;
	assign mif.waddr = widx_d; // R3
	assign mif.wdata = {red_d, grn_d, blu_d}; // R1
	assign mif.raddr = ridx_q; // R8

	// Reads wait two cycles, for the registered memory output and then the registered read data
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_q <= PLUT_IDLE;
		end else begin
			case (st_q)
				PLUT_IDLE: begin
					if (rd_r) begin
						st_q <= PLUT_WAIT;
					end
				end
				PLUT_WAIT: begin
					st_q <= PLUT_DONE;
				end
				PLUT_DONE: begin
					st_q <= PLUT_IDLE;
				end
				default: begin
					st_q <= PLUT_IDLE;
				end
			endcase
		end
	end

	assign pready_o = acc && (!rd_r || st_q == PLUT_DONE);
	assign pslverr_o = 1'b0;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prdata_q <= PLUT_RD_ZERO;
		end else if (rd_r && st_q == PLUT_WAIT) begin
			prdata_q <= PLUT_RD_ZERO; // R10
			prdata_q[PLUT_RED_LSB +: PLUT_COL_W] <= mif.rdata[17:12]; // R9
			prdata_q[PLUT_GRN_LSB +: PLUT_COL_W] <= mif.rdata[11:6]; // R9
			prdata_q[PLUT_BLU_LSB +: PLUT_COL_W] <= mif.rdata[5:0]; // R9
		end else begin
			// Cleared once the answer has stood for its one cycle
			prdata_q <= PLUT_RD_ZERO;
		end
	end

	// Write port and unmapped offsets always read zero
	assign prdata_o = prdata_q; // R2 R10

	chk_ridx_rport: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_r && pready_o && pstrb_i[PLUT_IDX_LANE]) |=> ridx_q ==
		$past(pwdata_i[31:24]))
		else $error("read index not loaded from read port"); // R8

	chk_commit_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
		(commit && pstrb_i[PLUT_IDX_LANE]) |-> mif.waddr == pwdata_i[31:24])
		else $error("commit not at index of this write"); // R3

	chk_rport_nocommit: assert property (@(posedge mclk_i)
		disable iff (rst_i) wr_r |-> !mif.we)
		else $error("read port write changed the tables"); // R10

	chk_rd_idle_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
		(st_q != PLUT_DONE) |-> prdata_o == PLUT_RD_ZERO)
		else $error("read data outside answer cycle"); // R10

	chk_wr_ready: assert property (@(posedge mclk_i) disable iff (rst_i)
		(acc && pwrite_i) |-> pready_o)
		else $error("write not answered in first access cycle"); // R4

	chk_ridx_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_w && pready_o && pstrb_i[3]) |=> ridx_q == $past(pwdata_i[31:24]))
		else $error("read index did not follow write index"); // R6

	chk_commit_le: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_w && pready_o && !host_endian_strap_i)
		|-> mif.we == pstrb_i[PLUT_IDX_LANE])
		else $error("little-endian commit not on index lane"); // R4

	chk_commit_be: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_w && pready_o && host_endian_strap_i)
		|-> mif.we == pstrb_i[PLUT_BLU_LANE])
		else $error("big-endian commit not on blue lane"); // R5

	chk_wport_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
		(acc && !pwrite_i && hit(paddr_i, PLUT_WRITE_PORT_OFS) && pready_o)
		|-> prdata_o == PLUT_RD_ZERO)
		else $error("write port read nonzero"); // R2

	chk_rd_unused: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_r && pready_o) |-> (prdata_o & 32'hff030303) == 32'h00000000)
		else $error("unused read bits nonzero"); // R10

	chk_rd_latency: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_r && st_q == PLUT_IDLE) |-> !pready_o ##1 !pready_o ##1 pready_o)
		else $error("read answer not on third access cycle"); // R9

	chk_rd_data: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_r && st_q == PLUT_WAIT) |=>
		prdata_o[23:18] == $past(mif.rdata[17:12]))
		else $error("red read data mismatch"); // R9

	chk_wdata_red: assert property (@(posedge mclk_i) disable iff (rst_i)
		(commit && pstrb_i[2]) |-> mif.wdata[17:12] == pwdata_i[23:18])
		else $error("red field not taken from bits 23-18"); // R7

	chk_rst_idx: assert property (@(posedge mclk_i)
		$past(rst_i) |-> (widx_q == 8'h00 && ridx_q == 8'h00))
		else $error("indices not zero after reset"); // R11
endmodule

// file: rtl/plut_pkg.sv
// Package with register map and field layout of the palette access port
package plut_pkg;
	localparam logic [11:0] PLUT_WRITE_PORT_OFS = 12'h018;
	localparam logic [11:0] PLUT_READ_PORT_OFS = 12'h01c;
	localparam int PLUT_IDX_LSB = 24;
	localparam int PLUT_RED_LSB = 18;
	localparam int PLUT_GRN_LSB = 10;
	localparam int PLUT_BLU_LSB = 2;
	localparam int PLUT_COL_W = 6;
	localparam int PLUT_IDX_W = 8;
	localparam int PLUT_DEPTH = 256;
	localparam logic [7:0] PLUT_IDX_RST = 8'h00;
	localparam int PLUT_IDX_LANE = 3;
	localparam int PLUT_BLU_LANE = 0;
	localparam logic [31:0] PLUT_RD_ZERO = 32'h00000000;
endpackage

// file: rtl/plut_mem_if.sv
// Interface between the port logic and the colour table memory
`timescale 1ns/1ps
interface plut_mem_if;
	logic we;
	logic [7:0] waddr;
	logic [17:0] wdata;
	logic [7:0] raddr;
	logic [17:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface

// file: rtl/plut_mem.sv
// Three-colour palette memory with registered read data
`timescale 1ns/1ps
module plut_mem
	import plut_pkg::*;
(
	input wire logic mclk_i,
	plut_mem_if.mem m
);
	// Red, green, blue side by side; no reset so contents stay undefined
	logic [17:0] ram [PLUT_DEPTH];
	logic [17:0] rdata_q;

	always_ff @(posedge mclk_i) begin
		if (m.we) begin
			ram[m.waddr] <= m.wdata; // R1
		end
	end

	always_ff @(posedge mclk_i) begin
		rdata_q <= ram[m.raddr];
	end

	assign m.rdata = rdata_q;
endmodule

// file: verification/plut_host.sv
// Host bus model issuing APB transfers to the palette port
`timescale 1ns/1ps
module plut_host (
	input wire logic mclk_i,
	input wire logic pready_i,
	input wire logic [31:0] prdata_i,
	input wire logic pslverr_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o,
	output logic [3:0] pstrb_o
);
	int tmo = 0;
	logic err = 1'b0;
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h00000000;
		pstrb_o = 4'h0;
	end
	function automatic logic [31:0] pack(logic [7:0] ix, logic [17:0] c);
		return {ix, c[17:12], 2'b00, c[11:6], 2'b00, c[5:0], 2'b00};
	endfunction
	// Called just after a rising edge; leaves one idle cycle behind it
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		int n;
		n = 0;
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		pstrb_o <= s;
		@(posedge mclk_i);
		penable_o <= 1'b1;
		@(posedge mclk_i);
		// Ready and read data are the values standing up to this edge
		while (pready_i !== 1'b1 && n < 20) begin
			@(posedge mclk_i);
			n++;
		end
		r = prdata_i;
		err = pslverr_i;
		if (pready_i !== 1'b1)
			tmo++;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released lines must not keep showing the old request
		paddr_o <= ~a;
		pwdata_o <= ~d;
		@(posedge mclk_i);
	endtask
endmodule

// file: verification/tb_palette_lut_access_port.sv
// Self-checking bench for the palette access port
`timescale 1ns/1ps
module tb_palette_lut_access_port
	import plut_pkg::*;
;
	localparam logic [11:0] W = PLUT_WRITE_PORT_OFS;
	localparam logic [11:0] R = PLUT_READ_PORT_OFS;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic strap = 1'b1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	int failures = 0;
	int n_compared = 0;
	always #12.5 mclk_i = ~mclk_i;
	plut_host u_host (.mclk_i(mclk_i), .pready_i(pready), .prdata_i(prdata),
		.pslverr_i(pslverr),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
	plut_port u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.host_endian_strap_i(strap), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata),
		.pslverr_o(pslverr));
	task automatic report_and_stop;
		failures += u_host.tmo;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
		u_host.xfer(1'b1, a, d, s, rd);
		if (u_host.tmo != 0)
			report_and_stop();
		cmp("pslverr", 32'h00000000, {31'h0, u_host.err});
	endtask
	task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
		u_host.xfer(1'b0, a, 32'h00000000, 4'h0, rd);
		if (u_host.tmo != 0)
			report_and_stop();
		cmp("pslverr", 32'h00000000, {31'h0, u_host.err});
		cmp(nm, e, rd);
	endtask
	initial begin
		logic [17:0] c;
		logic [7:0] ix;
		ix = 8'($urandom(44308));
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		c = 18'($urandom);
		wr(W, u_host.pack(8'h5a, c), 4'h1);
		rdc("reset entry", R, u_host.pack(8'h00, {12'h000, c[5:0]}));
		ix = 8'($urandom);
		c = 18'($urandom);
		wr(W, u_host.pack(ix, c), 4'he);
		wr(W, u_host.pack(8'h00, c), 4'h1);
		rdc("big endian", R, u_host.pack(8'h00, c));
		$display("test reset and big endian done");
		strap <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			ix = 8'($urandom);
			c = 18'($urandom);
			wr(W, u_host.pack(ix, c), 4'hf);
			rdc("entry", R, u_host.pack(8'h00, c));
		end
		$display("test random entries done");
		wr(W, u_host.pack(ix, ~c), 4'h7);
		wr(R, u_host.pack(ix, 18'h3ffff), 4'hf);
		rdc("no commit", R, u_host.pack(8'h00, c));
		wr(W, u_host.pack(ix, c), 4'h8);
		rdc("lane 3 commit", R, u_host.pack(8'h00, ~c));
		rdc("write port", W, 32'h00000000);
		wr(12'h020, 32'hffffffff, 4'hf);
		rdc("unmapped", 12'h020, 32'h00000000);
		rdc("entry kept", R, u_host.pack(8'h00, ~c));
		wr(W, u_host.pack(ix ^ 8'h80, c), 4'hf);
		wr(R, u_host.pack(ix, 18'h3ffff), 4'h8);
		rdc("read index", R, u_host.pack(8'h00, ~c));
		$display("test staging and decode done");
		report_and_stop();
	end
endmodule
